/* core/egsp_pulser.v */
// board-level global stop pulser for one pair of emulation event lines
`timescale 1ns/1ps
`include "egsp_map.vh"
module egsp_pulser #(
   parameter CLK_MHZ  = `EGSP_CLK_MHZ,
   parameter PULSE_NS = `EGSP_PULSE_NS
) (
   // clock and reset
   input  wire clk,
   input  wire resetn,
   // bused outgoing event line from the boards
   input  wire event_out_line,
   // count enable from the analysis equipment
   input  wire external_count_enable,
   // incoming event line, open-collector
   input  wire event_in_line_i,
   output wire event_in_line_o,
   output wire event_in_line_oe,
   // status
   output wire pulse_active
);

   ////////////////////////////////////////////////////////////////
   // pulse timing, all in local clock cycles
   // pulse length, rounded down to stay under the upper bound
   localparam integer PULSE_CYC_RAW = (PULSE_NS * CLK_MHZ) / 1000;
   // one test clock period, rounded up so that one cycle more is surely longer
   localparam integer TCK_CYC       = (`EGSP_TCK_PERIOD_NS * CLK_MHZ + 999) / 1000;
   localparam integer MAX_CYC       = `EGSP_PULSE_MAX_US * CLK_MHZ;
   // a width set outside the window is pulled back into it
   localparam integer PULSE_CYC_LO  = (PULSE_CYC_RAW <= TCK_CYC) ? TCK_CYC + 1 : PULSE_CYC_RAW;
   localparam integer PULSE_CYC_HI  = (PULSE_CYC_LO >= MAX_CYC) ? MAX_CYC - 1 : PULSE_CYC_LO;
   localparam integer PULSE_CYC     = (PULSE_CYC_HI < 1) ? 1 : PULSE_CYC_HI;
   // the counter saturates at its own width; a faster clock needs a wider counter
   localparam integer CNT_MAX       = (1 << `EGSP_CNT_W) - 1;
   localparam integer LAST_INT      = (PULSE_CYC - 1 > CNT_MAX) ? CNT_MAX : PULSE_CYC - 1;
   localparam [`EGSP_CNT_W-1:0] CNT_LAST = LAST_INT[`EGSP_CNT_W-1:0];

   ////////////////////////////////////////////////////////////////
   // state codes
   localparam [1:0] ST_IDLE    = 2'h0;
   localparam [1:0] ST_PULSE   = 2'h1;
   localparam [1:0] ST_WAIT    = 2'h2;
   localparam [1:0] ST_RELEASE = 2'h3;

   ////////////////////////////////////////////////////////////////
   // pin positions in the synchroniser bank
   localparam integer PIN_OUT  = 0;
   localparam integer PIN_CNT  = 1;
   localparam integer PIN_BACK = 2;
   localparam integer PIN_N    = 3;

   ////////////////////////////////////////////////////////////////
   // every pin is asynchronous to clk and passes two flip-flops
   // resetting to high keeps the block passive until real levels arrive
   wire [PIN_N-1:0] pin_raw;
   wire [PIN_N-1:0] pin_s;
   assign pin_raw[PIN_OUT]  = event_out_line;
   assign pin_raw[PIN_CNT]  = external_count_enable;
   assign pin_raw[PIN_BACK] = event_in_line_i;
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_sync
         egsp_sync #(
            .RESET_VAL (1'b1)
         ) u_sync (
            .clk    (clk),
            .resetn (resetn),
            .d      (pin_raw[gi]),
            .q      (pin_s[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // state, counter and drive registers
   reg [1:0]             st_q;
   reg [1:0]             st_d;
   reg [`EGSP_CNT_W-1:0] cnt_q;
   reg [`EGSP_CNT_W-1:0] cnt_d;
   reg                   drive_q;
   reg                   drive_d;

   ////////////////////////////////////////////////////////////////
   // qualified conditions
   wire out_low_s;
   wire cnt_en_s;
   wire line_free_s;
   wire start_ok;
   wire start_blocked;
   wire pulse_done;
   wire rearm_ok;
   assign out_low_s     = ~pin_s[PIN_OUT];
   assign cnt_en_s      = pin_s[PIN_CNT];
   assign line_free_s   = pin_s[PIN_BACK];
   // in external count the processor pins are push-pull, so this driver stays off
   assign start_ok      = out_low_s && !cnt_en_s; // RULE1 RULE3 RULE4
   // a low seen during counting is ignored and needs a fresh high to rearm
   assign start_blocked = out_low_s && cnt_en_s; // RULE3 RULE11
   assign pulse_done    = (cnt_q == CNT_LAST); // RULE2 RULE12
   // split paths: our own pulse must have left the inward line before rearming
   assign rearm_ok      = !out_low_s && line_free_s; // RULE9 RULE11

   ////////////////////////////////////////////////////////////////
   // next state
   always @* begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_IDLE: begin
            if (start_ok) begin // RULE1
               st_d  = ST_PULSE;
               cnt_d = {`EGSP_CNT_W{1'b0}};
            end else if (start_blocked) begin // RULE3
               st_d = ST_WAIT;
            end
         end
         ST_PULSE: begin
            if (cnt_en_s) begin // RULE3
               st_d = ST_RELEASE;
            end else if (pulse_done) begin // RULE2 RULE12
               st_d = ST_RELEASE;
            end else begin
               cnt_d = cnt_q + 1'b1; // RULE12
            end
         end
         ST_RELEASE: begin
            // the readback lags the drive by the synchroniser, so this takes a few cycles
            cnt_d = {`EGSP_CNT_W{1'b0}};
            if (line_free_s) begin // RULE9
               st_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (rearm_ok) begin // RULE11
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d  = ST_IDLE;
            cnt_d = {`EGSP_CNT_W{1'b0}};
         end
      endcase
   end
   always @(posedge clk) begin
      if (!resetn) begin
         st_q  <= ST_IDLE;
         cnt_q <= {`EGSP_CNT_W{1'b0}};
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // open-collector: drive low only, otherwise released to the pullup
   // registered so the pin never glitches while the state decodes
   always @* begin
      drive_d = 1'b0;
      if ((st_d == ST_PULSE) && !cnt_en_s) begin // RULE3 RULE4
         // the low level halts every processor set up to stop on it
         drive_d = 1'b1; // RULE1 RULE8
      end
   end
   always @(posedge clk) begin
      if (!resetn) begin
         drive_q <= 1'b0;
      end else begin
         drive_q <= drive_d; // RULE5 RULE6 RULE9
      end
   end
   assign event_in_line_o  = 1'b0; // RULE6
   assign event_in_line_oe = drive_q;
   assign pulse_active     = drive_q;
endmodule // egsp_pulser

/* pkg/egsp_map.vh */
// constants for the emulation global stop pulser
// Operation
// RULE1: a low seen on the bused outgoing event line starts a low pulse inward
// RULE2: inward pulse lasts over one test clock period and under 10 us
// RULE3: while external count is enabled the inward line stays high, never driven
// RULE4: in external count the processor pins are push-pull, carry and halted status
// RULE5: an inactive event pin is released and never drives the shared line
// RULE6: signal events pull the line low through open-collector drive only
// RULE7: outside sources stay inactive whenever any processor counts externally
// RULE8: a processor set up for it halts when its event pin goes low
// RULE9: the shared signal is split into inward and outward paths at the edge
// RULE10: software returns the outgoing event pins high after a stop event
// RULE11: one pulse per low level; rearm only after the outgoing line is high
// RULE12: the pulse width comes from a counter on the local clock
`ifndef EGSP_MAP_VH
`define EGSP_MAP_VH
`define EGSP_CLK_MHZ        40
`define EGSP_TCK_PERIOD_NS  100
`define EGSP_PULSE_MAX_US   10
`define EGSP_PULSE_NS       1000
`define EGSP_CNT_W          9
`endif

/* core/egsp_sync.v */
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module egsp_sync #(
   parameter RESET_VAL = 1'b1
) (
   // clock and reset
   input  wire clk,
   input  wire resetn,
   // level
   input  wire d,
   output wire q
);
   reg meta_q;
   reg sync_q;
   always @(posedge clk) begin
      if (!resetn) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end
   assign q = sync_q;
endmodule // egsp_sync

/* test/egsp_far.sv */
// far side: pulled-up inward line seen by the boards
`timescale 1ns/1ps
module egsp_far (
   input  wire oe,
   input  wire o,
   output wire line,
   output wire halted
);
   assign line = oe ? o : 1'b1;
   assign halted = !line;
endmodule // egsp_far

/* test/egsp_chk.sv */
// assertions on the stop pulser pins
`timescale 1ns/1ps
module egsp_chk (
   // clock and reset
   input wire clk,
   input wire resetn,
   // watched pins
   input wire event_out_line,
   input wire external_count_enable,
   input wire event_in_line_i,
   input wire event_in_line_o,
   input wire event_in_line_oe,
   input wire pulse_active
);
   wire o = event_out_line, e = external_count_enable, oe = event_in_line_oe;
   reg [5:0] cnt_q;
   reg       hi_q;
   always @(posedge clk) begin
      cnt_q <= (resetn && oe) ? cnt_q + 6'h01 : 6'h00;
      hi_q <= !resetn || o || (hi_q && !oe);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_start; $rose(oe); endsequence
   a_pulse_cause: assert property (s_start |-> !$past(o, 3)) else $error("start");
   a_no_spur: assert property (o [*5] |-> !$rose(oe)) else $error("spur");
   a_width_max: assert property (oe |-> cnt_q < 6'h28) else $error("long");
   a_width_exact: assert property ($fell(oe) && !e |-> cnt_q == 6'h28) else $error("width");
   a_count_quiet: assert property (e [*5] |-> !oe) else $error("count");
   a_count_block: assert property (s_start |-> !$past(e, 3)) else $error("enable");
   a_open_drain: assert property (event_in_line_o == 1'b0) else $error("data");
   a_one_shot: assert property (s_start |-> $past(hi_q)) else $error("rearm");
   a_status_same: assert property (pulse_active == oe) else $error("status");
endmodule // egsp_chk
bind egsp_pulser egsp_chk chk (.*);

/* test/testbench.sv */
// self-checking bench for the stop pulser
`timescale 1ns/1ps
module testbench;
   reg     clk = 0;
   reg     resetn = 0;
   reg     o = 1;
   reg     e = 0;
   wire    in_i;
   wire    in_o;
   wire    oe;
   wire    act;
   wire    halt;
   integer miscompares = 0;
   integer n_tests = 0;
   integer i;
   always #12.5 clk = ~clk;
   egsp_pulser DUT (
      .clk                   (clk),
      .resetn                (resetn),
      .event_out_line        (o),
      .external_count_enable (e),
      .event_in_line_i       (in_i),
      .event_in_line_o       (in_o),
      .event_in_line_oe      (oe),
      .pulse_active          (act)
   );
   egsp_far far (
      .oe     (oe),
      .o      (in_o),
      .line   (in_i),
      .halted (halt)
   );
   task chk(input a, input b); begin
      n_tests = n_tests + 1;
      if (a !== b) begin
         miscompares = miscompares + 1;
         $display("wrong value %0t line", $time);
      end
   end endtask
   task final_report; begin
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   end endtask
   task timed_out; begin
      miscompares = miscompares + 1;
      $display("wrong value %0t wait ran out", $time);
      final_report;
   end endtask
   task c(input integer n); repeat (n) @(negedge clk); endtask
   task t_stop; begin
      o = 0;
      i = 0;
      while (in_i !== 1'b0 && i < 20) begin
         c(1);
         i = i + 1;
      end
      if (i == 20) timed_out;
      chk(act, 1'b1);
      chk(halt, 1'b1);
      i = 0;
      while (in_i === 1'b0 && i < 60) begin
         c(1);
         i = i + 1;
      end
      if (i == 60) timed_out;
      chk(i == 40, 1'b1);
      chk(act, 1'b0);
      c(50);
      chk(in_i, 1'b1);
      o = 1;
      c(5);
   end endtask
   task t_count; begin
      e = 1;
      c(4);
      o = 0;
      repeat (60) begin
         c(1);
         chk(in_i, 1'b1);
      end
      e = 0;
      c(20);
      chk(in_i, 1'b1);
      o = 1;
      c(5);
   end endtask
   task t_abort; begin
      o = 0;
      c(10);
      chk(in_i, 1'b0);
      e = 1;
      c(4);
      chk(in_i, 1'b1);
      chk(act, 1'b0);
      o = 1;
      e = 0;
      c(5);
   end endtask
   task t_reset; begin
      o = 0;
      c(10);
      chk(in_i, 1'b0);
      resetn = 0;
      c(3);
      chk(in_i, 1'b1);
      o = 1;
      resetn = 1;
      c(5);
   end endtask
   initial begin
      c(5);
      resetn = 1;
      c(3);
      t_stop;
      t_stop;
      t_count;
      t_abort;
      t_stop;
      t_reset;
      t_stop;
      final_report;
   end
endmodule // testbench
